// [logic/charger_regs_consts.svh]
// Constants for the charger status and configuration register bank
`ifndef CHARGER_REGS_CONSTS_SVH
`define CHARGER_REGS_CONSTS_SVH
`define SLAVE_ADDR          7'h48
`define OFS_STATUS          8'h01
`define OFS_CONFIG_MAIN     8'h02
`define OFS_CONFIG_CURRENTS 8'h03
`define RST_CONFIG_MAIN     8'h6f
`define RST_CONFIG_CURRENTS 8'h54
`define CURRENTS_RW_MASK    8'hfc
`define BIT_HOT             7
`define BIT_COLD            6
`define BIT_OVP             5
`define BIT_ACTIVE          3
`define BIT_PGOOD           2
`define BIT_REDUCE          1
`define RELEASE_DELAY_MS    100
`define CLOCK_MHZ           100
`define RELEASE_CYCLES      (`RELEASE_DELAY_MS * 1000 * `CLOCK_MHZ)
`endif

// [logic/charger_regs_pkg.sv]
// Types for the charger status and configuration register bank
package charger_regs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b011,
    ST_DATA = 3'b010,
    ST_RACK = 3'b110,
    ST_SKIP = 3'b111
  } i2c_state_t;
endpackage

// [logic/charger_status_config_regs.sv]
// Charger status/configuration registers behind an I2C slave port
`timescale 1ns/1ps
`include "charger_regs_consts.svh"

// Function
// RL1: Undervoltage lockout loads all register defaults
// RL2: Reset loads defaults; reset output released 100ms later
// RL3: Status register is read-only
// RL4: Status bit 7 shows battery too hot
// RL5: Status bit 6 shows battery too cold
// RL6: Status bit 5 shows input overvoltage
// RL7: Status bit 3 shows charging active
// RL8: Status bit 2 shows input power valid
// RL9: Status bit 1 shows current reduction active
// RL10: Config bits 7..6 select system rail
// RL11: Battery-tracking rail forces power-path threshold
// RL12: Config bits 5..4 select input current limit
// RL13: Input current code 11 means suspend
// RL14: Config bit 3 enables thermal regulation
// RL15: Config bit 2 enables timer slowdown
// RL16: Config bit 1 enables charge termination
// RL17: Config bit 0 enables charger
// RL18: Currents bits 7..6 select precharge factor
// RL19: Currents bits 5..4 scale charge current
// RL20: Currents bits 3..2 select termination factor
// RL21: Suspend turns input switch off, battery on
// RL22: I2C slave at address 1001000
// RL23: Unmapped register reads return zero
// RL24: Unused bits ignore writes, read fixed
module charger_status_config_regs #(
  parameter int unsigned RELEASE_CYCLES = `RELEASE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       undervoltage_lockout_i,
  output logic            reset_out_o,
  // I2C pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Analog status inputs
  input  wire logic       battery_too_hot_flag_i,
  input  wire logic       battery_too_cold_flag_i,
  input  wire logic       input_overvoltage_flag_i,
  input  wire logic       charging_active_flag_i,
  input  wire logic       input_power_valid_flag_i,
  input  wire logic       current_reduction_active_flag_i,
  // Configuration outputs
  output logic [1:0]      system_rail_select_o,
  output logic            power_path_threshold_forced_o,
  output logic [1:0]      input_current_limit_select_o,
  output logic            input_dynamic_power_path_enable_o,
  output logic            bus_suspend_o,
  output logic            input_switch_on_o,
  output logic            battery_switch_on_o,
  output logic            thermal_regulation_enable_o,
  output logic            timer_slowdown_enable_o,
  output logic            termination_enable_o,
  output logic            charger_enable_o,
  output logic [1:0]      precharge_current_factor_o,
  output logic [1:0]      charge_current_scale_o,
  output logic [1:0]      termination_current_factor_o
);
  import charger_regs_pkg::*;

  // Pin and status synchronisers, two stages each
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  wire  [8:0] raw_in = {scl_i, sda_i, undervoltage_lockout_i,
                        battery_too_hot_flag_i, battery_too_cold_flag_i,
                        input_overvoltage_flag_i, charging_active_flag_i,
                        input_power_valid_flag_i, current_reduction_active_flag_i};
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 9'h180; // Pins idle high so no false edge follows reset
      sync2_reg <= 9'h180;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end
  wire scl_s = sync2_reg[8];
  wire sda_s = sync2_reg[7];
  wire undervoltage_lockout_s = sync2_reg[6];

  // Previous pin levels for edge and start/stop detection
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Defaults load on lockout as well as on reset
  wire load_defaults = undervoltage_lockout_s; // RL1

  // Reset output release counter; held low during lockout
  logic [$clog2(RELEASE_CYCLES+1)-1:0] rel_cnt_reg;
  wire rel_done = (rel_cnt_reg == ($clog2(RELEASE_CYCLES+1))'(RELEASE_CYCLES));
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rel_cnt_reg <= '0;
    end else if (load_defaults) begin
      rel_cnt_reg <= '0; // RL2
    end else if (!rel_done) begin
      rel_cnt_reg <= rel_cnt_reg + 1'b1;
    end
  end
  assign reset_out_o = rel_done; // RL2

  // Register storage
  logic [7:0] config_main_reg;
  logic [7:0] config_currents_reg;

  // Live status word; bits 4 and 0 fixed at zero
  wire [7:0] status_word = {sync2_reg[5], sync2_reg[4], sync2_reg[3], 1'b0,
                            sync2_reg[2], sync2_reg[1], sync2_reg[0], 1'b0}; // RL4 RL5 RL6 RL7 RL8 RL9 RL24

  // I2C slave engine
  i2c_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       rw_reg;
  logic       first_byte_reg; // Pointer byte still to come
  logic       addr_phase_reg; // Ack in progress belongs to the address byte
  logic [7:0] ptr_reg;
  logic       sda_drive_reg;

  // Read data selection; unmapped addresses read as zero
  logic [7:0] read_word;
  assign read_word = (ptr_reg == `OFS_STATUS)          ? status_word :
                     (ptr_reg == `OFS_CONFIG_MAIN)     ? config_main_reg :
                     (ptr_reg == `OFS_CONFIG_CURRENTS) ? config_currents_reg :
                     8'h00; // RL23

  wire addr_match = (shift_reg[7:1] == `SLAVE_ADDR); // RL22
  wire wr_byte    = (state_reg == ST_ACK) && scl_fall && !first_byte_reg && !rw_reg &&
                    !addr_phase_reg;

  // Bus protocol sequencer; ignored entirely while defaults load
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg      <= ST_IDLE;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      rw_reg         <= 1'b0;
      first_byte_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      ptr_reg        <= 8'h00;
      sda_drive_reg  <= 1'b0;
    end else if (load_defaults || stop_c) begin
      state_reg     <= ST_IDLE;
      sda_drive_reg <= 1'b0;
    end else if (start_c) begin
      state_reg     <= ST_ADDR; // RL22
      bit_cnt_reg   <= 4'h0;
      sda_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_DATA: begin
          if (scl_rise && !(state_reg == ST_DATA && rw_reg)) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_rise && state_reg == ST_DATA && rw_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_fall && state_reg == ST_DATA && rw_reg) begin
            if (bit_cnt_reg == 4'h8) begin
              sda_drive_reg <= 1'b0;
              state_reg     <= ST_RACK;
            end else begin
              sda_drive_reg <= ~shift_reg[7 - bit_cnt_reg[2:0]];
            end
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (state_reg == ST_ADDR && !addr_match) begin
              state_reg <= ST_SKIP;
            end else begin
              if (state_reg == ST_ADDR) begin
                rw_reg         <= shift_reg[0];
                first_byte_reg <= ~shift_reg[0];
                addr_phase_reg <= 1'b1;
              end
              sda_drive_reg <= 1'b1; // Acknowledge by pulling low
              state_reg     <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg    <= 4'h0;
            addr_phase_reg <= 1'b0;
            if (rw_reg) begin
              shift_reg     <= read_word;
              sda_drive_reg <= ~read_word[7];
              ptr_reg       <= ptr_reg + 8'h01;
            end else begin
              sda_drive_reg <= 1'b0;
              // Shift register still holds the address here, so it must not become the pointer
              if (first_byte_reg && !addr_phase_reg) begin
                ptr_reg        <= shift_reg;
                first_byte_reg <= 1'b0;
              end else if (!addr_phase_reg) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
            state_reg <= ST_DATA;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_reg <= ST_SKIP; // Master ends read with no-ack
            end else begin
              state_reg <= ST_ACK;
            end
          end
        end
        ST_SKIP: begin
          sda_drive_reg <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // Open-drain: the line only ever goes low
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_drive_reg;

  // Config stores; the status address has no storage, so writes drop
  wire wr_main     = wr_byte && (ptr_reg == `OFS_CONFIG_MAIN);
  wire wr_currents = wr_byte && (ptr_reg == `OFS_CONFIG_CURRENTS); // RL3
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_main_reg     <= `RST_CONFIG_MAIN; // RL2
      config_currents_reg <= `RST_CONFIG_CURRENTS;
    end else if (load_defaults) begin
      config_main_reg     <= `RST_CONFIG_MAIN; // RL1
      config_currents_reg <= `RST_CONFIG_CURRENTS;
    end else begin
      if (wr_main) begin
        config_main_reg <= shift_reg;
      end
      if (wr_currents) begin
        config_currents_reg <= (shift_reg & `CURRENTS_RW_MASK) |
                               (`RST_CONFIG_CURRENTS & ~`CURRENTS_RW_MASK); // RL24
      end
    end
  end

  // Field decode toward the power path and charger
  assign system_rail_select_o          = config_main_reg[7:6]; // RL10
  assign power_path_threshold_forced_o = (config_main_reg[7:6] == 2'b00); // RL11
  assign input_current_limit_select_o  = config_main_reg[5:4]; // RL12
  assign input_dynamic_power_path_enable_o = ~config_main_reg[5]; // RL12
  assign bus_suspend_o       = (config_main_reg[5:4] == 2'b11) | sync2_reg[3]; // RL13 overvoltage too
  assign input_switch_on_o   = ~bus_suspend_o; // RL21
  assign battery_switch_on_o = 1'b1; // RL21
  assign thermal_regulation_enable_o  = config_main_reg[3]; // RL14
  assign timer_slowdown_enable_o      = config_main_reg[2]; // RL15
  assign termination_enable_o         = config_main_reg[1]; // RL16
  assign charger_enable_o             = config_main_reg[0]; // RL17
  assign precharge_current_factor_o   = config_currents_reg[7:6]; // RL18
  assign charge_current_scale_o       = config_currents_reg[5:4]; // RL19
  assign termination_current_factor_o = config_currents_reg[3:2]; // RL20

  // Checks
  property p_undervoltage_lockout_defaults;
    @(posedge clock_i) disable iff (!rstn_i)
      undervoltage_lockout_s |=> (config_main_reg == `RST_CONFIG_MAIN);
  endproperty
  a_undervoltage_lockout_defaults: assert property (p_undervoltage_lockout_defaults) else $error("no defaults in lockout"); // RL1
  property p_reset_low;
    @(posedge clock_i) disable iff (!rstn_i) undervoltage_lockout_s |=> !reset_out_o;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("reset out high in lockout"); // RL2
  property p_status_ro;
    @(posedge clock_i) disable iff (!rstn_i)
      wr_byte && ptr_reg == `OFS_STATUS |=> $stable(config_main_reg) && $stable(config_currents_reg);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed store"); // RL3
  property p_hot;
    @(posedge clock_i) disable iff (!rstn_i) $past(battery_too_hot_flag_i, 2) == status_word[7];
  endproperty
  a_hot: assert property (p_hot) else $error("hot bit wrong"); // RL4
  property p_fixed_bits;
    @(posedge clock_i) disable iff (!rstn_i)
      status_word[4] == 1'b0 && status_word[0] == 1'b0 && config_currents_reg[1:0] == 2'b00;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits changed"); // RL24
  property p_suspend;
    @(posedge clock_i) disable iff (!rstn_i)
      config_main_reg[5:4] == 2'b11 |-> bus_suspend_o && !input_switch_on_o && battery_switch_on_o;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend switches wrong"); // RL13
  property p_unmapped;
    @(posedge clock_i) disable iff (!rstn_i) ptr_reg > `OFS_CONFIG_CURRENTS |-> read_word == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // RL23
  property p_write_main;
    @(posedge clock_i) disable iff (!rstn_i)
      wr_main && !load_defaults |=> config_main_reg == $past(shift_reg);
  endproperty
  a_write_main: assert property (p_write_main) else $error("config write lost"); // RL17
  property p_rail_force;
    @(posedge clock_i) disable iff (!rstn_i)
      power_path_threshold_forced_o == (system_rail_select_o == 2'b00);
  endproperty
  a_rail_force: assert property (p_rail_force) else $error("threshold force wrong"); // RL11
  property p_status;
    @(posedge clock_i) disable iff (!rstn_i)
      {status_word[6:5], status_word[3:1]} == {$past(battery_too_cold_flag_i, 2),
        $past(input_overvoltage_flag_i, 2), $past(charging_active_flag_i, 2),
        $past(input_power_valid_flag_i, 2), $past(current_reduction_active_flag_i, 2)};
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong"); // RL5 RL6 RL7 RL8 RL9
  property p_ovp_standby;
    @(posedge clock_i) disable iff (!rstn_i)
      $past(input_overvoltage_flag_i, 2) |-> bus_suspend_o && !input_switch_on_o;
  endproperty
  a_ovp_standby: assert property (p_ovp_standby) else $error("overvoltage left input on"); // RL21
  property p_skip_quiet;
    @(posedge clock_i) disable iff (!rstn_i) state_reg == ST_SKIP |-> !sda_oe_o;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("sda driven in skip"); // RL22
  property p_release_holds;
    @(posedge clock_i) disable iff (!rstn_i) reset_out_o && !load_defaults |=> reset_out_o;
  endproperty
  a_release_holds: assert property (p_release_holds) else $error("reset out fell"); // RL2
  property p_write_currents;
    @(posedge clock_i) disable iff (!rstn_i)
      wr_currents && !load_defaults |=> config_currents_reg[7:2] == $past(shift_reg[7:2]);
  endproperty
  a_write_currents: assert property (p_write_currents) else $error("currents write lost"); // RL19
  c_skip: cover property (@(posedge clock_i) disable iff (!rstn_i) state_reg == ST_SKIP);
  c_write_main: cover property (@(posedge clock_i) disable iff (!rstn_i) wr_main);
  c_read_status: cover property (@(posedge clock_i) disable iff (!rstn_i)
    state_reg == ST_ACK && rw_reg && ptr_reg == `OFS_STATUS);
  c_release: cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(reset_out_o));
endmodule // charger_status_config_regs

// [test/i2c_host_model.sv]
// Behavioural I2C bus master that reaches the register bank
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int QTR = 6
) (
  input  wire logic clock_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Bus idles released; SDA has a pull-up, so release reads as 1
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One bit: data moves only while SCL is low, sampled mid-high
  task automatic xfer_bit(input logic out_bit, output logic in_bit);
    scl_o <= 1'b0;
    wait_clk(QTR);
    sda_o <= out_bit;
    wait_clk(QTR);
    scl_o <= 1'b1;
    wait_clk(QTR);
    in_bit = sda_line_i;
    wait_clk(QTR);
  endtask
  // Start and repeated start: SDA falls while SCL is high
  task automatic start_cond();
    scl_o <= 1'b0;
    wait_clk(QTR);
    sda_o <= 1'b1;
    wait_clk(QTR);
    scl_o <= 1'b1;
    wait_clk(2 * QTR);
    sda_o <= 1'b0;
    wait_clk(2 * QTR);
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop_cond();
    scl_o <= 1'b0;
    wait_clk(QTR);
    sda_o <= 1'b0;
    wait_clk(QTR);
    scl_o <= 1'b1;
    wait_clk(2 * QTR);
    sda_o <= 1'b1;
    wait_clk(2 * QTR);
  endtask
  // Byte out MSB first; the ninth clock samples the slave's ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], unused);
    end
    xfer_bit(1'b1, unused);
    ack = ~unused;
  endtask
  // Byte in MSB first, then the master's ack or nack
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, b[i]);
    end
    xfer_bit(nack, unused);
  endtask
endmodule // i2c_host_model

// [test/tb_charger_status_config_regs.sv]
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
`include "charger_regs_consts.svh"
module tb_charger_status_config_regs;
  localparam int REL = 20;
  typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic [7:0] rd;} row_t;
  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       undervoltage_lockout = 1'b0;
  logic       hot = 1'b0, cold = 1'b0, input_overvoltage_flag = 1'b0, act = 1'b0, pg = 1'b0, red = 1'b0;
  logic       scl, host_sda, sda_o, sda_oe, rst_out;
  logic [1:0] rail, ilim, pre, scale, tfac;
  logic       forced, dyn, susp, insw, batsw, th, slow, term, en;
  logic [7:0] main_m = `RST_CONFIG_MAIN;
  logic [7:0] cur_m = `RST_CONFIG_CURRENTS;
  logic [7:0] rd;
  int         errors = 0;
  int         total_checks = 0;
  // SDA is pulled up; the slave only ever pulls it low
  wire        sda_line = host_sda & ~(sda_oe & ~sda_o);
  wire [18:0] outs = {rail, forced, ilim, dyn, susp, insw, batsw, th, slow, term, en,
                      pre, scale, tfac};
  row_t rows[9] = '{'{8'h02, 8'h00, 8'h00}, '{8'h02, 8'h55, 8'h55}, '{8'h02, 8'haa, 8'haa},
                    '{8'h02, 8'hb0, 8'hb0}, '{8'h03, 8'h00, 8'h00}, '{8'h03, 8'hff, 8'hfc},
                    '{8'h03, 8'ha9, 8'ha8}, '{8'h01, 8'hff, 8'h8c}, '{8'h07, 8'hff, 8'h00}};

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  charger_status_config_regs #(.RELEASE_CYCLES(REL)) i_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .undervoltage_lockout_i(undervoltage_lockout),
    .reset_out_o(rst_out), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .battery_too_hot_flag_i(hot), .battery_too_cold_flag_i(cold),
    .input_overvoltage_flag_i(input_overvoltage_flag), .charging_active_flag_i(act),
    .input_power_valid_flag_i(pg), .current_reduction_active_flag_i(red),
    .system_rail_select_o(rail), .power_path_threshold_forced_o(forced),
    .input_current_limit_select_o(ilim), .input_dynamic_power_path_enable_o(dyn),
    .bus_suspend_o(susp), .input_switch_on_o(insw), .battery_switch_on_o(batsw),
    .thermal_regulation_enable_o(th), .timer_slowdown_enable_o(slow),
    .termination_enable_o(term), .charger_enable_o(en),
    .precharge_current_factor_o(pre), .charge_current_scale_o(scale),
    .termination_current_factor_o(tfac));

  i2c_host_model i_host (.clock_i(clock_i), .sda_line_i(sda_line), .scl_o(scl),
                         .sda_o(host_sda));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic compare(input logic [18:0] got, input logic [18:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Expected configuration outputs from register images and overvoltage
  function automatic logic [18:0] outs_exp(input logic [7:0] m, input logic [7:0] c,
                                           input logic ov);
    logic s;
    s = (m[5:4] == 2'b11) | ov;
    return {m[7:6], m[7:6] == 2'b00, m[5:4], ~m[5], s, ~s, 1'b1, m[3:0], c[7:2]};
  endfunction

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    logic [2:0] a;
    i_host.start_cond();
    i_host.send_byte({`SLAVE_ADDR, 1'b0}, a[2]);
    i_host.send_byte(ofs, a[1]);
    i_host.send_byte(d, a[0]);
    i_host.stop_cond();
    compare({16'h0, a}, 19'h7, "write acks");
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [2:0] a;
    i_host.start_cond();
    i_host.send_byte({`SLAVE_ADDR, 1'b0}, a[2]);
    i_host.send_byte(ofs, a[1]);
    i_host.start_cond();
    i_host.send_byte({`SLAVE_ADDR, 1'b1}, a[0]);
    i_host.recv_byte(1'b1, d);
    i_host.stop_cond();
    compare({16'h0, a}, 19'h7, "read acks");
  endtask

  // Bounded wait for the reset output to rise after reset ends
  task automatic wait_release();
    for (int i = 0; i < 100 && rst_out !== 1'b1; i++) @(posedge clock_i);
    if (rst_out !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: reset output stuck low", $time);
      tally_and_finish();
    end
    repeat (4) @(posedge clock_i);
  endtask

  task automatic check_defaults(input string what);
    read_reg(`OFS_CONFIG_MAIN, rd);
    compare({11'h0, rd}, {11'h0, `RST_CONFIG_MAIN}, what);
    read_reg(`OFS_CONFIG_CURRENTS, rd);
    compare({11'h0, rd}, {11'h0, `RST_CONFIG_CURRENTS}, what);
    compare(outs, outs_exp(`RST_CONFIG_MAIN, `RST_CONFIG_CURRENTS, 1'b0), what);
  endtask

  // Watchdog so that a hang still reaches the verdict
  initial begin
    repeat (100000) @(posedge clock_i);
    errors++;
    $display("unexpected at %0t: run timeout", $time);
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    hot <= 1'b1;
    act <= 1'b1;
    pg <= 1'b1;
    repeat (5) @(posedge clock_i);
    compare({18'h0, rst_out}, 19'h0, "reset output held");
    wait_release();
    check_defaults("reset defaults");
    // Table: write, read back, then compare every configuration output
    foreach (rows[i]) begin
      write_reg(rows[i].ofs, rows[i].wd);
      read_reg(rows[i].ofs, rd);
      compare({11'h0, rd}, {11'h0, rows[i].rd}, "readback");
      if (rows[i].ofs == `OFS_CONFIG_MAIN) main_m = rows[i].wd;
      if (rows[i].ofs == `OFS_CONFIG_CURRENTS) cur_m = rows[i].wd & `CURRENTS_RW_MASK;
      compare(outs, outs_exp(main_m, cur_m, 1'b0), "config outputs");
    end
    // Leave suspend first so that only overvoltage can force standby below
    write_reg(`OFS_CONFIG_MAIN, 8'h41);
    main_m = 8'h41;
    // Complementary status pattern; overvoltage also forces standby
    hot <= 1'b0;
    act <= 1'b0;
    pg <= 1'b0;
    cold <= 1'b1;
    input_overvoltage_flag <= 1'b1;
    red <= 1'b1;
    read_reg(`OFS_STATUS, rd);
    compare({11'h0, rd}, 19'h62, "status pattern");
    compare(outs, outs_exp(main_m, cur_m, 1'b1), "overvoltage standby");
    input_overvoltage_flag <= 1'b0;
    // Foreign address gets no ack
    i_host.start_cond();
    i_host.send_byte({`SLAVE_ADDR + 7'h01, 1'b0}, rd[0]);
    i_host.stop_cond();
    compare({18'h0, rd[0]}, 19'h0, "foreign address ack");
    compare(outs, outs_exp(main_m, cur_m, 1'b0), "overvoltage cleared");
    // Undervoltage lockout in mid-run reloads defaults
    undervoltage_lockout <= 1'b1;
    repeat (10) @(posedge clock_i);
    compare({18'h0, rst_out}, 19'h0, "lockout reset output");
    undervoltage_lockout <= 1'b0;
    wait_release();
    check_defaults("lockout defaults");
    tally_and_finish();
  end
endmodule // tb_charger_status_config_regs
